//--- design/jtr_pkg.sv
// constants and carrier types for the test port instruction and data chains
// assumes a tck domain and a 200 MHz system clock domain for the core side
// Contract
// - no processor-mapped registers; everything is reached serially through the port
// - four-bit instruction shift chain with separate parallel holding register
// - held instruction after update selects the data chain and test behaviour
// - codes 0000 extest, 0001 intest, 0010 sample/preload
// - codes 1000 abort, 1010 debug-port access, 1011 access-port access
// - code 1110 idcode, 1111 bypass with one shift stage
// - every unlisted code behaves exactly as bypass
// - extest drives pad output and enable from preload cells
// - intest feeds core pad inputs from preload input cells
// - reset pin is one observe-only input cell, never driven
// - sample/preload captures pad input, output, enable in capture-dr
// - shift-dr shifts tdi to tdo; update-dr copies into preload registers
// - chain ordered by pad, each pad gives input, output, enable
// - abort, debug-port and access-port chains are 35 bits long
// - suitable abort data clears error flags or aborts pending request
// - access-port chain reaches internal buses; debug-port chain reaches control
// - idcode loaded on power-on reset, trst, and test-logic-reset
// - 32-bit identity chain with lsb 1, fixed identity value
// - bypass chain one stage capturing 0
// - exactly six data chains
// - power-on reset resets the port; external reset pin does not
package jtr_pkg;
	localparam int JTR_IR_W = 4;
	localparam int JTR_ACC_W = 35;
	localparam int JTR_ID_W = 32;
	localparam int JTR_NPAD = 8;
	localparam int JTR_BSR_W = 3 * JTR_NPAD + 1;
	localparam logic [3:0] JTR_OP_EXTEST = 4'h0;
	localparam logic [3:0] JTR_OP_INTEST = 4'h1;
	localparam logic [3:0] JTR_OP_SAMPLE = 4'h2;
	localparam logic [3:0] JTR_OP_ABORT = 4'h8;
	localparam logic [3:0] JTR_OP_DP_ACC = 4'ha;
	localparam logic [3:0] JTR_OP_AP_ACC = 4'hb;
	localparam logic [3:0] JTR_OP_IDCODE = 4'he;
	localparam logic [3:0] JTR_OP_BYPASS = 4'hf;
	localparam logic [1:0] JTR_IR_CAPTURE = 2'h1;
	// identity value is arbitrary, lsb must stay 1
	localparam logic [31:0] JTR_IDCODE_VAL = 32'h1234_5679;
	localparam logic [2:0] JTR_ACK_OK = 3'h2;
	typedef enum logic [3:0] {
		JTR_TLR = 4'hf, JTR_RTI = 4'hc, JTR_SEL_DR = 4'h7, JTR_CAP_DR = 4'h6,
		JTR_SH_DR = 4'h2, JTR_EX1_DR = 4'h1, JTR_PA_DR = 4'h3,
		JTR_EX2_DR = 4'h0, JTR_UP_DR = 4'h5, JTR_SEL_IR = 4'h4,
		JTR_CAP_IR = 4'he, JTR_SH_IR = 4'ha, JTR_EX1_IR = 4'h9,
		JTR_PA_IR = 4'hb, JTR_EX2_IR = 4'h8, JTR_UP_IR = 4'hd
	} jtr_state_type;
	typedef enum logic [2:0] {
		JTR_CH_BYPASS, JTR_CH_ID, JTR_CH_BSR, JTR_CH_ABORT, JTR_CH_DP, JTR_CH_AP
	} jtr_chain_type;
	typedef struct packed {
		logic [JTR_NPAD-1:0] in;
		logic [JTR_NPAD-1:0] out;
		logic [JTR_NPAD-1:0] oe;
	} jtr_pads_type;
	typedef struct packed {
		logic valid;
		logic is_ap;
		logic rnw;
		logic [1:0] addr;
		logic [31:0] data;
	} jtr_req_type;
endpackage

//--- design/jtr_sync.sv
// three-stage level synchroniser into the destination clock
// assumes the input is quasi-static relative to the destination clock
`timescale 1ns/10ps
module jtr_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q_o <= '0;
		end else begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				q_o <= s3;
		end
	end
endmodule

//--- design/jtr_tap.sv
// test access port: state machine, instruction register, six data chains
// assumes rst_n_i is power-on reset only, tck runs from the tester
`timescale 1ns/10ps
module jtr_tap
	import jtr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tck_i,
	input wire logic trst_n_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	input wire logic ext_rst_n_i,
	input wire jtr_pads_type core_i,
	input wire logic [JTR_NPAD-1:0] pad_in_i,
	output logic [JTR_NPAD-1:0] pad_out_o,
	output logic [JTR_NPAD-1:0] pad_oe_o,
	output logic [JTR_NPAD-1:0] core_in_o,
	output jtr_req_type dap_req_o,
	input wire logic [31:0] dap_rdata_i,
	input wire logic [2:0] dap_ack_i,
	output logic dap_abort_o,
	output logic [3:0] dap_clr_o
);
	jtr_state_type state;
	jtr_state_type next_state;
	logic tap_rst_n;
	logic [3:0] ir_sh;
	logic [3:0] ir;
	logic bypass_sh;
	logic [JTR_ID_W-1:0] id_sh;
	logic [JTR_BSR_W-1:0] bsr_sh;
	logic [JTR_BSR_W-1:0] bsr_pre;
	logic [JTR_ACC_W-1:0] acc_sh;
	logic [JTR_BSR_W-1:0] bsr_cap;
	logic [JTR_NPAD-1:0] cap_in;
	logic req_tgl;
	logic abort_tgl;
	jtr_req_type req_hold;
	logic [3:0] abort_hold;
	logic req_sync;
	logic abt_sync;
	logic req_seen;
	logic abt_seen;
	logic [31:0] rdata_q;
	logic [2:0] ack_q;

	// tap reset: power-on or trst only, external reset pin not used
	assign tap_rst_n = rst_n_i & trst_n_i;

	// instruction decode
	function automatic jtr_chain_type sel_chain(input logic [3:0] op);
		case (op)
			JTR_OP_EXTEST, JTR_OP_INTEST, JTR_OP_SAMPLE: sel_chain = JTR_CH_BSR;
			JTR_OP_ABORT: sel_chain = JTR_CH_ABORT;
			JTR_OP_DP_ACC: sel_chain = JTR_CH_DP;
			JTR_OP_AP_ACC: sel_chain = JTR_CH_AP;
			JTR_OP_IDCODE: sel_chain = JTR_CH_ID;
			default: sel_chain = JTR_CH_BYPASS;
		endcase
	endfunction

	wire jtr_chain_type chain = sel_chain(ir);
	wire is_extest = (ir == JTR_OP_EXTEST);
	wire is_intest = (ir == JTR_OP_INTEST);
	wire is_acc = (chain == JTR_CH_DP) || (chain == JTR_CH_AP);

	// state machine
	always_comb begin
		case (state)
			JTR_TLR: next_state = tms_i ? JTR_TLR : JTR_RTI;
			JTR_RTI: next_state = tms_i ? JTR_SEL_DR : JTR_RTI;
			JTR_SEL_DR: next_state = tms_i ? JTR_SEL_IR : JTR_CAP_DR;
			JTR_CAP_DR: next_state = tms_i ? JTR_EX1_DR : JTR_SH_DR;
			JTR_SH_DR: next_state = tms_i ? JTR_EX1_DR : JTR_SH_DR;
			JTR_EX1_DR: next_state = tms_i ? JTR_UP_DR : JTR_PA_DR;
			JTR_PA_DR: next_state = tms_i ? JTR_EX2_DR : JTR_PA_DR;
			JTR_EX2_DR: next_state = tms_i ? JTR_UP_DR : JTR_SH_DR;
			JTR_UP_DR: next_state = tms_i ? JTR_SEL_DR : JTR_RTI;
			JTR_SEL_IR: next_state = tms_i ? JTR_TLR : JTR_CAP_IR;
			JTR_CAP_IR: next_state = tms_i ? JTR_EX1_IR : JTR_SH_IR;
			JTR_SH_IR: next_state = tms_i ? JTR_EX1_IR : JTR_SH_IR;
			JTR_EX1_IR: next_state = tms_i ? JTR_UP_IR : JTR_PA_IR;
			JTR_PA_IR: next_state = tms_i ? JTR_EX2_IR : JTR_PA_IR;
			JTR_EX2_IR: next_state = tms_i ? JTR_UP_IR : JTR_SH_IR;
			JTR_UP_IR: next_state = tms_i ? JTR_SEL_DR : JTR_RTI;
			default: next_state = JTR_TLR;
		endcase
	end

	always_ff @(posedge tck_i or negedge tap_rst_n) begin
		if (!tap_rst_n)
			state <= JTR_TLR;
		else
			state <= next_state;
	end

	// instruction register: shift chain and parallel holding register
	always_ff @(posedge tck_i or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			ir_sh <= JTR_OP_IDCODE;
		end else if (state == JTR_CAP_IR) begin
			ir_sh <= {2'h0, JTR_IR_CAPTURE};
		end else if (state == JTR_SH_IR) begin
			ir_sh <= {tdi_i, ir_sh[3:1]};
		end
	end

	// holding register updates on falling tck, idcode in test-logic-reset
	always_ff @(negedge tck_i or negedge tap_rst_n) begin
		if (!tap_rst_n)
			ir <= JTR_OP_IDCODE;
		else if (state == JTR_TLR)
			ir <= JTR_OP_IDCODE;
		else if (state == JTR_UP_IR)
			ir <= ir_sh;
	end

	// boundary capture: per pad input, output, enable; reset pin at top
	genvar g;
	generate
		for (g = 0; g < JTR_NPAD; g++) begin : g_bsr
			assign bsr_cap[3*g+2] = pad_in_i[g];
			assign bsr_cap[3*g+1] = core_i.out[g];
			assign bsr_cap[3*g] = core_i.oe[g];
			assign pad_out_o[g] = is_extest ? bsr_pre[3*g+1] : core_i.out[g];
			assign pad_oe_o[g] = is_extest ? bsr_pre[3*g] : core_i.oe[g];
			assign cap_in[g] = bsr_pre[3*g+2];
		end
	endgenerate
	assign bsr_cap[JTR_BSR_W-1] = ext_rst_n_i;
	assign core_in_o = is_intest ? cap_in : pad_in_i;

	// data chains
	always_ff @(posedge tck_i or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			bypass_sh <= 1'b0;
			id_sh <= '0;
			bsr_sh <= '0;
			acc_sh <= '0;
		end else if (state == JTR_CAP_DR) begin
			bypass_sh <= 1'b0;
			id_sh <= JTR_IDCODE_VAL;
			if (chain == JTR_CH_BSR)
				bsr_sh <= bsr_cap;
			if (is_acc)
				acc_sh <= {rdata_q, ack_q};
			else if (chain == JTR_CH_ABORT)
				acc_sh <= '0;
		end else if (state == JTR_SH_DR) begin
			case (chain)
				JTR_CH_ID: id_sh <= {tdi_i, id_sh[JTR_ID_W-1:1]};
				JTR_CH_BSR: bsr_sh <= {tdi_i, bsr_sh[JTR_BSR_W-1:1]};
				JTR_CH_ABORT, JTR_CH_DP, JTR_CH_AP:
					acc_sh <= {tdi_i, acc_sh[JTR_ACC_W-1:1]};
				default: bypass_sh <= tdi_i;
			endcase
		end
	end

	// preload registers update on falling tck in update-dr
	always_ff @(negedge tck_i or negedge tap_rst_n) begin
		if (!tap_rst_n)
			bsr_pre <= '0;
		else if (state == JTR_UP_DR && chain == JTR_CH_BSR)
			bsr_pre <= bsr_sh[JTR_BSR_W-1:0];
	end

	// access requests handed to the system domain by toggle
	// power-on reset only, so trst cannot fake a toggle edge
	always_ff @(negedge tck_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_tgl <= 1'b0;
			abort_tgl <= 1'b0;
			req_hold <= '0;
			abort_hold <= '0;
		end else if (state == JTR_UP_DR) begin
			if (is_acc) begin
				req_tgl <= ~req_tgl;
				req_hold.valid <= 1'b1;
				req_hold.is_ap <= (chain == JTR_CH_AP);
				req_hold.data <= acc_sh[34:3];
				req_hold.addr <= acc_sh[2:1];
				req_hold.rnw <= acc_sh[0];
			end else if (chain == JTR_CH_ABORT) begin
				abort_tgl <= ~abort_tgl;
				abort_hold <= {acc_sh[7:5], acc_sh[3]};
			end
		end
	end

	// returned read data and ack from system domain, quasi-static words
	always_ff @(posedge tck_i or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			rdata_q <= '0;
			ack_q <= JTR_ACK_OK;
		end else if (state == JTR_SEL_DR) begin
			rdata_q <= dap_rdata_i;
			ack_q <= dap_ack_i;
		end
	end

	// system clock side of the crossings
	jtr_sync #(.W(1)) u_req_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i(req_tgl),
		.q_o(req_sync)
	);
	jtr_sync #(.W(1)) u_abt_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i(abort_tgl),
		.q_o(abt_sync)
	);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_seen <= 1'b0;
			abt_seen <= 1'b0;
			dap_req_o <= '0;
			dap_abort_o <= 1'b0;
			dap_clr_o <= '0;
		end else begin
			req_seen <= req_sync;
			abt_seen <= abt_sync;
			dap_req_o <= '0;
			dap_abort_o <= 1'b0;
			dap_clr_o <= '0;
			if (req_sync != req_seen)
				dap_req_o <= req_hold;
			if (abt_sync != abt_seen) begin
				dap_abort_o <= abort_hold[0];
				dap_clr_o <= {abort_hold[3:1], 1'b0};
			end
		end
	end

	// tdo changes on falling tck from the selected chain
	wire tdo_src = (state == JTR_SH_IR) ? ir_sh[0] :
		(chain == JTR_CH_ID) ? id_sh[0] :
		(chain == JTR_CH_BSR) ? bsr_sh[0] :
		(is_acc || chain == JTR_CH_ABORT) ? acc_sh[0] : bypass_sh;
	wire shifting = (state == JTR_SH_IR) || (state == JTR_SH_DR);

	always_ff @(negedge tck_i or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			tdo_o <= 1'b0;
			tdo_oe_o <= 1'b0;
		end else begin
			tdo_o <= tdo_src;
			tdo_oe_o <= shifting;
		end
	end
endmodule

//--- verification/jtr_tap_properties.sv
// checker for the test port: pulse widths, tdo timing, shift exit
// assumes tdo and its enable change on falling tck only
`timescale 1ns/10ps
module jtr_tap_checker
	import jtr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tck_i,
	input wire logic trst_n_i,
	input wire logic tms_i,
	input wire logic tdo_o,
	input wire logic tdo_oe_o,
	input wire jtr_req_type dap_req_o,
	input wire logic dap_abort_o,
	input wire logic [3:0] dap_clr_o
);
	sequence leave_shift;
		tdo_oe_o && tms_i;
	endsequence
	sequence stay_shift;
		tdo_oe_o && !tms_i;
	endsequence
	oe_test_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!trst_n_i |-> !tdo_oe_o) else $error("tdo enabled in test reset");
	tdo_on_fall_a: assert property (@(posedge clk_i)
		disable iff (!rst_n_i || !trst_n_i) $changed(tdo_o) |-> !tck_i)
		else $error("tdo moved while tck high");
	oe_on_fall_a: assert property (@(posedge clk_i)
		disable iff (!rst_n_i || !trst_n_i) $rose(tdo_oe_o) |-> !tck_i)
		else $error("tdo enable rose while tck high");
	shift_exit_a: assert property (@(posedge tck_i)
		disable iff (!rst_n_i || !trst_n_i) leave_shift |=> !tdo_oe_o)
		else $error("shift not left on tms high");
	shift_hold_a: assert property (@(posedge tck_i)
		disable iff (!rst_n_i || !trst_n_i) stay_shift |=> tdo_oe_o)
		else $error("shift left on tms low");
	req_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		dap_req_o.valid |=> !dap_req_o.valid) else $error("request too long");
	req_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(dap_req_o.valid) |-> !tdo_oe_o) else $error("request in shift");
	abort_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		dap_abort_o |=> !dap_abort_o) else $error("abort too long");
	clr_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		dap_clr_o != 4'h0 |=> dap_clr_o == 4'h0) else $error("clear too long");
endmodule
bind jtr_tap jtr_tap_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.tck_i(tck_i), .trst_n_i(trst_n_i), .tms_i(tms_i), .tdo_o(tdo_o),
	.tdo_oe_o(tdo_oe_o), .dap_req_o(dap_req_o), .dap_abort_o(dap_abort_o),
	.dap_clr_o(dap_clr_o));

//--- verification/jtr_tester.sv
// tester model: drives tck, tms, tdi and samples tdo
// assumes tdo is presented on falling tck; tck idles low between frames
`timescale 1ns/10ps
module jtr_tester (
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o,
	input wire logic tdo_i
);
	int pause = 0;
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
	end
	task automatic step(input logic ms, input logic di, output logic o);
		tms_o = ms;
		tdi_o = di;
		#24;
		o = tdo_i;
		tck_o = 1'b1;
		#24;
		tck_o = 1'b0;
	endtask
	task automatic tlr();
		logic o;
		repeat (5) step(1'b1, ~tdi_o, o);
		step(1'b0, ~tdi_o, o);
	endtask
	task automatic scan(input bit ir, input int n, input logic [34:0] di,
		output logic [34:0] dq);
		logic o;
		dq = '0;
		#(pause);
		step(1'b1, ~tdi_o, o);
		if (ir) step(1'b1, ~tdi_o, o);
		step(1'b0, ~tdi_o, o);
		step(1'b0, ~tdi_o, o);
		for (int i = 0; i < n; i++) step(i == n - 1, di[i], dq[i]);
		step(1'b1, ~tdi_o, o);
		step(1'b0, ~tdi_o, o);
	endtask
endmodule

//--- verification/testbench.sv
// self-checking bench for the test port chains
// assumes the tester model drives the port and the bench the pads
`timescale 1ns/10ps
`define CHK(a, b, s) begin checks++; if ((a) !== (b)) begin mismatches++; \
	$display("CHECK FAILED %0t %s", $time, s); end end
module testbench
	import jtr_pkg::*;
;
	logic clk_i = 0, rst_n_i = 1, trst_n_i = 1, ext_rst_n_i = 1;
	logic tck, tms, tdi, tdo_o, tdo_oe_o, dap_abort_o;
	jtr_pads_type core_i = '0;
	logic [JTR_NPAD-1:0] pad_in_i = '0, pad_out_o, pad_oe_o, core_in_o;
	jtr_req_type dap_req_o, req;
	logic [31:0] dap_rdata_i = '0;
	logic [2:0] dap_ack_i = '0;
	logic [3:0] dap_clr_o, clr = '0;
	logic [34:0] d;
	int mismatches = 0, checks = 0, nreq = 0, nabort = 0;
	jtr_tester m (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_o));
	jtr_tap u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .tck_i(tck),
		.trst_n_i(trst_n_i), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo_o),
		.tdo_oe_o(tdo_oe_o), .ext_rst_n_i(ext_rst_n_i), .core_i(core_i),
		.pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
		.core_in_o(core_in_o), .dap_req_o(dap_req_o),
		.dap_rdata_i(dap_rdata_i), .dap_ack_i(dap_ack_i),
		.dap_abort_o(dap_abort_o), .dap_clr_o(dap_clr_o));
	always #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (dap_req_o.valid === 1'b1) begin
			req <= dap_req_o;
			nreq <= nreq + 1;
		end
		if (dap_abort_o === 1'b1) nabort <= nabort + 1;
		if (dap_clr_o !== 4'h0) clr <= dap_clr_o;
	end
	task automatic load_ir(input logic [3:0] op);
		m.scan(1, 4, {31'h0, op}, d);
		`CHK(d[3:0], 4'h1, "ir capture")
	endtask
	task automatic t_bypass();
		logic [3:0] ops [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hc,
			4'hd, 4'hf};
		foreach (ops[i]) begin
			load_ir(ops[i]);
			m.scan(0, 3, 35'h3, d);
			`CHK(d[2:0], 3'b110, "bypass path")
		end
	endtask
	task automatic t_boundary();
		logic [24:0] e, p;
		p = 25'h1b4_c3a5;
		@(negedge clk_i);
		pad_in_i = 8'ha5;
		core_i = {8'h00, 8'h3c, 8'hf0};
		ext_rst_n_i = 1'b0;
		for (int g = 0; g < JTR_NPAD; g++)
			e[3*g+:3] = {pad_in_i[g], core_i.out[g], core_i.oe[g]};
		e[24] = ext_rst_n_i;
		load_ir(JTR_OP_SAMPLE);
		m.scan(0, 25, {10'h0, p}, d);
		`CHK(d[24:0], e, "boundary capture")
		`CHK(pad_out_o, core_i.out, "pads from core")
		for (int g = 0; g < JTR_NPAD; g++)
			{e[16+g], e[g], e[8+g]} = p[3*g+:3];
		load_ir(JTR_OP_EXTEST);
		`CHK(pad_out_o, e[7:0], "extest out")
		`CHK(pad_oe_o, e[15:8], "extest enable")
		`CHK(core_in_o, pad_in_i, "core from pads")
		load_ir(JTR_OP_INTEST);
		`CHK(core_in_o, e[23:16], "intest in")
		`CHK(pad_out_o, core_i.out, "intest out")
		ext_rst_n_i = 1'b1;
	endtask
	task automatic dap_one(input logic [3:0] op, input logic ap,
		input logic [34:0] di);
		int k;
		k = nreq;
		load_ir(op);
		m.scan(0, 35, di, d);
		`CHK(d, {dap_rdata_i, dap_ack_i}, "access capture")
		repeat (20) @(posedge clk_i);
		`CHK(nreq, k + 1, "request count")
		`CHK(req, jtr_req_type'({1'b1, ap, di[0], di[2:1], di[34:3]}),
			"request")
	endtask
	task automatic t_dap();
		int k;
		@(negedge clk_i);
		dap_rdata_i = 32'hcafe_0123;
		dap_ack_i = JTR_ACK_OK;
		dap_one(JTR_OP_DP_ACC, 1'b0, {32'h5a5a_1234, 2'h2, 1'b0});
		dap_one(JTR_OP_AP_ACC, 1'b1, {32'h0bad_f00d, 2'h1, 1'b1});
		k = nabort;
		load_ir(JTR_OP_ABORT);
		m.scan(0, 35, 35'he8, d);
		repeat (20) @(posedge clk_i);
		`CHK(nabort, k + 1, "abort pulse")
		`CHK(clr, 4'he, "abort clears")
	endtask
	task automatic t_reset();
		int a0, r0;
		a0 = nabort;
		r0 = nreq;
		for (int k = 0; k < 3; k++) begin
			load_ir(JTR_OP_BYPASS);
			@(negedge clk_i);
			if (k == 0) trst_n_i = 1'b0;
			if (k == 1) rst_n_i = 1'b0;
			repeat (10) @(negedge clk_i);
			trst_n_i = 1'b1;
			rst_n_i = 1'b1;
			m.tlr();
			m.scan(0, 32, '0, d);
			`CHK(d[31:0], JTR_IDCODE_VAL, "idcode after reset")
		end
		`CHK(nabort, a0, "no abort from reset")
		`CHK(nreq, r0, "no request from reset")
	endtask
	task automatic finish_test();
		if (mismatches == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#400000;
		mismatches++;
		finish_test();
	end
	initial begin
		#1;
		rst_n_i = 1'b0;
		trst_n_i = 1'b0;
		repeat (10) @(posedge clk_i);
		@(negedge clk_i);
		rst_n_i = 1'b1;
		trst_n_i = 1'b1;
		m.tlr();
		m.scan(0, 32, '0, d);
		`CHK(d[31:0], JTR_IDCODE_VAL, "idcode at start")
		t_bypass();
		t_boundary();
		m.pause = 200;
		t_dap();
		t_reset();
		finish_test();
	end
endmodule
